// >>> inc/uifc_pkg.sv
package uifc_pkg;
  // =====================================================
  // register addresses (3-bit host bus)
  localparam logic [2:0] ADDR_RX_TX = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_IIR_FCR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_TCR = 3'h6;
  localparam logic [2:0] ADDR_TLR_XOFF2 = 3'h7;
  // line control value that opens the enhanced bank
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
  localparam int LCR_DLAB = 7;
  // =====================================================
  // enable bit positions
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam int IE_LS = 2;
  localparam int IE_MS = 3;
  localparam int IE_SLEEP = 4;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  // enhanced feature bit positions
  localparam int EF_WREN = 4;
  localparam int EF_SPECIAL = 5;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  // modem control bit position and write lock masks
  localparam int MC_ACCESS = 6;
  localparam logic [7:0] MC_LOCK_MASK = 8'hE0;
  localparam logic [7:0] FC_LOCK_MASK = 8'h30;
  localparam logic [7:0] IE_LOCK_MASK = 8'hF0;
  // =====================================================
  // identification codes on bits 5:1
  localparam logic [4:0] ID_LINE = 5'h03;
  localparam logic [4:0] ID_TIMEOUT = 5'h06;
  localparam logic [4:0] ID_RX = 5'h02;
  localparam logic [4:0] ID_TX = 5'h01;
  localparam logic [4:0] ID_MODEM = 5'h00;
  localparam logic [4:0] ID_XOFF = 5'h08;
  localparam logic [4:0] ID_FLOW = 5'h10;
  // =====================================================
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] THR_STEP_SHIFT = 7'h02;
endpackage : uifc_pkg

// >>> verilog/uifc_intr_id.sv
`timescale 1ns/10ps
module uifc_intr_id (
  input wire logic i_line_err,
  input wire logic i_rx_timeout,
  input wire logic i_rx_ready,
  input wire logic i_tx_pend,
  input wire logic i_modem_pend,
  input wire logic i_xoff_pend,
  input wire logic i_flow_pend,
  output logic o_pending,
  output logic [4:0] o_code
);
  // =====================================================
  // priority encoder, all inputs already gated by enables
  always_comb
  begin
    o_pending = 1'b1;
    if (i_line_err) o_code = uifc_pkg::ID_LINE;
    else if (i_rx_timeout) o_code = uifc_pkg::ID_TIMEOUT;
    else if (i_rx_ready) o_code = uifc_pkg::ID_RX;
    else if (i_tx_pend) o_code = uifc_pkg::ID_TX;
    else if (i_modem_pend) o_code = uifc_pkg::ID_MODEM;
    else if (i_xoff_pend) o_code = uifc_pkg::ID_XOFF;
    else if (i_flow_pend) o_code = uifc_pkg::ID_FLOW;
    else
    begin
      o_code = uifc_pkg::ID_MODEM;
      o_pending = 1'b0;
    end
  end
endmodule : uifc_intr_id

// >>> verilog/uifc_flow_ctl.sv
`timescale 1ns/10ps
module uifc_flow_ctl (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_auto_rts,
  input wire logic i_auto_cts,
  input wire logic [7:0] i_threshold,
  input wire logic [6:0] i_rx_level,
  input wire logic i_cts_pin,
  output logic o_rts_pin,
  output logic o_tx_halt
);
  logic rts_q;
  logic rts_d;
  logic [6:0] halt_lvl;
  logic [6:0] resume_lvl;
  // =====================================================
  // nibble times four gives the byte count
  function automatic logic [6:0] nib_bytes(input logic [3:0] n);
    nib_bytes = {1'b0, n, 2'b00};
  endfunction : nib_bytes
  assign halt_lvl = nib_bytes(i_threshold[3:0]);
  assign resume_lvl = nib_bytes(i_threshold[7:4]);
  always_comb
  begin
    rts_d = rts_q;
    if (!i_auto_rts) rts_d = 1'b0;
    else if (i_rx_level >= halt_lvl) rts_d = 1'b1;
    else if (i_rx_level <= resume_lvl) rts_d = 1'b0;
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst) rts_q <= 1'b0;
    else rts_q <= rts_d;
  end
  assign o_rts_pin = rts_q;
  // halting on a high cts level
  assign o_tx_halt = i_auto_cts & i_cts_pin;
  rts_halt_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_auto_rts && $past(i_auto_rts) && i_rx_level >= halt_lvl) |=> o_rts_pin)
    else $error("rts not raised at halt level");
  cts_halt_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_auto_cts && i_cts_pin) |-> o_tx_halt)
    else $error("tx not halted on cts high");
endmodule : uifc_flow_ctl

// >>> verilog/uifc_top.sv
`timescale 1ns/10ps
// Contract
// - enable bits 0-3 gate rx, tx, line, modem
// - sleep only while enable bit 4 set
// - enable bits 5-7 gate xoff, rts, cts; here bit 6 or bit 7 unmasks both rts and cts changes
// - re-enabling tx raises no fresh interrupt
// - interrupt output active for enabled source
// - id bit 0 low while pending
// - id bit4 special char, bit5 flow change
// - id bits 7:6 mirror fifo enable
// - line 3, timeout 6, rx 2 codes
// - tx priority 3, modem priority 4
// - xoff priority 5, flow change 6
// - feature bits 3:0 pick software flow
// - feature bit 4 write-enables locked bits
// - special char match sets id bit 4
// - auto rts high at halt, low resume
// - auto cts halts tx on high cts
// - divisor is high byte then low byte
// - divisor writable only while sleep off
// - threshold nibbles: halt low, resume high
// - threshold write needs feature4 and modem6
// - modem bit 6 opens threshold access
module uifc_top (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic [6:0] i_rx_level,
  input wire logic i_tx_below,
  input wire logic i_line_err,
  input wire logic i_rx_timeout,
  input wire logic i_rx_ready,
  input wire logic i_modem_chg,
  input wire logic i_xoff_rcvd,
  input wire logic i_cts_pin,
  output logic o_rts_pin,
  output logic o_tx_halt,
  output logic o_intr,
  output logic o_sleep,
  output logic [15:0] o_divisor,
  output logic [3:0] o_sw_flow_mode,
  output logic o_fifo_mode
);
  logic [7:0] ier_q, ier_d, efr_q, efr_d, lcr_q, lcr_d, mcr_q, mcr_d;
  logic [7:0] fcr_q, fcr_d, dll_q, dll_d, dlh_q, dlh_d, tcr_q, tcr_d;
  logic [7:0] tlr_q, tlr_d, xoff2_q, xoff2_d;
  logic tx_pend_q, tx_pend_d, spec_q, spec_d, flow_q, flow_d;
  logic rts_prev_q, cts_prev_q, tx_below_q;
  logic enh_bank, dlab, pending, tx_arm, id_read;
  logic [4:0] code;
  logic [7:0] interrupt_source_id;
  // =====================================================
  // locked bits keep their value unless feature bit 4 set
  function automatic logic [7:0] lock_merge(input logic [7:0] old_v,
    input logic [7:0] new_v, input logic [7:0] mask, input logic wren);
    lock_merge = wren ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction : lock_merge
  assign enh_bank = (lcr_q == uifc_pkg::LCR_ENH_KEY);
  assign dlab = lcr_q[uifc_pkg::LCR_DLAB];
  // =====================================================
  // register writes
  always_comb
  begin
    ier_d = ier_q;
    efr_d = efr_q;
    lcr_d = lcr_q;
    mcr_d = mcr_q;
    fcr_d = fcr_q;
    dll_d = dll_q;
    dlh_d = dlh_q;
    tcr_d = tcr_q;
    tlr_d = tlr_q;
    xoff2_d = xoff2_q;
    if (i_wr)
    begin
      if (i_addr == uifc_pkg::ADDR_LCR) lcr_d = i_wdata;
      else if (enh_bank && i_addr == uifc_pkg::ADDR_IIR_FCR) efr_d = i_wdata;
      else if (enh_bank && i_addr == uifc_pkg::ADDR_TLR_XOFF2) xoff2_d = i_wdata;
      else if (dlab && !ier_q[uifc_pkg::IE_SLEEP] && i_addr == uifc_pkg::ADDR_RX_TX)
        dll_d = i_wdata;
      else if (dlab && !ier_q[uifc_pkg::IE_SLEEP] && i_addr == uifc_pkg::ADDR_IER)
        dlh_d = i_wdata;
      else if (dlab || enh_bank) ier_d = ier_q;
      else if (i_addr == uifc_pkg::ADDR_IER)
        ier_d = lock_merge(ier_q, i_wdata, uifc_pkg::IE_LOCK_MASK,
          efr_q[uifc_pkg::EF_WREN]);
      else if (i_addr == uifc_pkg::ADDR_IIR_FCR)
        fcr_d = lock_merge(fcr_q, i_wdata, uifc_pkg::FC_LOCK_MASK,
          efr_q[uifc_pkg::EF_WREN]);
      else if (i_addr == uifc_pkg::ADDR_MCR)
        mcr_d = lock_merge(mcr_q, i_wdata, uifc_pkg::MC_LOCK_MASK,
          efr_q[uifc_pkg::EF_WREN]);
      else if (i_addr == uifc_pkg::ADDR_TCR && efr_q[uifc_pkg::EF_WREN]
        && mcr_q[uifc_pkg::MC_ACCESS]) tcr_d = i_wdata;
      else if (i_addr == uifc_pkg::ADDR_TLR_XOFF2 && efr_q[uifc_pkg::EF_WREN]
        && mcr_q[uifc_pkg::MC_ACCESS]) tlr_d = i_wdata;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ier_q <= uifc_pkg::RESET_BYTE;
      efr_q <= uifc_pkg::RESET_BYTE;
      lcr_q <= uifc_pkg::RESET_BYTE;
      mcr_q <= uifc_pkg::RESET_BYTE;
      fcr_q <= uifc_pkg::RESET_BYTE;
      dll_q <= uifc_pkg::RESET_BYTE;
      dlh_q <= uifc_pkg::RESET_BYTE;
      tcr_q <= uifc_pkg::RESET_BYTE;
      tlr_q <= uifc_pkg::RESET_BYTE;
      xoff2_q <= uifc_pkg::RESET_BYTE;
    end
    else
    begin
      ier_q <= ier_d;
      efr_q <= efr_d;
      lcr_q <= lcr_d;
      mcr_q <= mcr_d;
      fcr_q <= fcr_d;
      dll_q <= dll_d;
      dlh_q <= dlh_d;
      tcr_q <= tcr_d;
      tlr_q <= tlr_d;
      xoff2_q <= xoff2_d;
    end
  end
  // =====================================================
  // event flags; a new event beats a read clear
  assign id_read = i_rd && i_addr == uifc_pkg::ADDR_IIR_FCR && !enh_bank && !dlab;
  // tx arms only on a fresh below-threshold edge, not on re-enable
  assign tx_arm = i_tx_below && !tx_below_q;
  always_comb
  begin
    tx_pend_d = tx_pend_q;
    spec_d = spec_q;
    flow_d = flow_q;
    if (!i_tx_below) tx_pend_d = 1'b0;
    else if (id_read && code == uifc_pkg::ID_TX) tx_pend_d = 1'b0;
    if (tx_arm) tx_pend_d = 1'b1;
    if (id_read) spec_d = 1'b0;
    if (i_xoff_rcvd) spec_d = 1'b1;
    if (i_rx_valid && efr_q[uifc_pkg::EF_SPECIAL] && i_rx_char == xoff2_q)
      spec_d = 1'b1;
    if (id_read) flow_d = 1'b0;
    if ((o_rts_pin && !rts_prev_q) || (i_cts_pin && !cts_prev_q))
      flow_d = 1'b1;
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_pend_q <= 1'b0;
      spec_q <= 1'b0;
      flow_q <= 1'b0;
      rts_prev_q <= 1'b0;
      cts_prev_q <= 1'b0;
      tx_below_q <= 1'b0;
    end
    else
    begin
      tx_pend_q <= tx_pend_d;
      spec_q <= spec_d;
      flow_q <= flow_d;
      rts_prev_q <= o_rts_pin;
      cts_prev_q <= i_cts_pin;
      tx_below_q <= i_tx_below;
    end
  end
  // =====================================================
  // sources gated by enables
  uifc_intr_id u_id (
    .i_line_err(i_line_err & ier_q[uifc_pkg::IE_LS]),
    .i_rx_timeout(i_rx_timeout & ier_q[uifc_pkg::IE_RX]),
    .i_rx_ready(i_rx_ready & ier_q[uifc_pkg::IE_RX]),
    .i_tx_pend(tx_pend_q & ier_q[uifc_pkg::IE_TX]),
    .i_modem_pend(i_modem_chg & ier_q[uifc_pkg::IE_MS]),
    .i_xoff_pend(spec_q & ier_q[uifc_pkg::IE_XOFF]),
    .i_flow_pend(flow_q & (ier_q[uifc_pkg::IE_RTS] | ier_q[uifc_pkg::IE_CTS])),
    .o_pending(pending),
    .o_code(code)
  );
  uifc_flow_ctl u_flow (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_auto_rts(efr_q[uifc_pkg::EF_AUTO_RTS]),
    .i_auto_cts(efr_q[uifc_pkg::EF_AUTO_CTS]),
    .i_threshold(tcr_q),
    .i_rx_level(i_rx_level),
    .i_cts_pin(i_cts_pin),
    .o_rts_pin(o_rts_pin),
    .o_tx_halt(o_tx_halt)
  );
  // =====================================================
  // identification and outputs
  assign interrupt_source_id = {{2{fcr_q[0]}}, code, ~pending};
  assign o_intr = pending;
  assign o_sleep = ier_q[uifc_pkg::IE_SLEEP];
  assign o_divisor = {dlh_q, dll_q};
  assign o_sw_flow_mode = efr_q[3:0];
  assign o_fifo_mode = fcr_q[0];
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst) o_rdata <= uifc_pkg::RESET_BYTE;
    else if (dlab && i_addr == uifc_pkg::ADDR_RX_TX) o_rdata <= dll_q;
    else if (dlab && i_addr == uifc_pkg::ADDR_IER) o_rdata <= dlh_q;
    else if (enh_bank && i_addr == uifc_pkg::ADDR_IIR_FCR) o_rdata <= efr_q;
    else if (i_addr == uifc_pkg::ADDR_IER) o_rdata <= ier_q;
    else if (i_addr == uifc_pkg::ADDR_IIR_FCR) o_rdata <= interrupt_source_id;
    else if (i_addr == uifc_pkg::ADDR_LCR) o_rdata <= lcr_q;
    else if (i_addr == uifc_pkg::ADDR_MCR) o_rdata <= mcr_q;
    else if (i_addr == uifc_pkg::ADDR_TCR && mcr_q[uifc_pkg::MC_ACCESS]) o_rdata <= tcr_q;
    else if (i_addr == uifc_pkg::ADDR_TLR_XOFF2 && mcr_q[uifc_pkg::MC_ACCESS])
      o_rdata <= tlr_q;
    else o_rdata <= uifc_pkg::RESET_BYTE;
  end
  // =====================================================
  intr_out_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_line_err && ier_q[uifc_pkg::IE_LS]) |-> (o_intr && code == uifc_pkg::ID_LINE))
    else $error("line error not reported first");
  sleep_lock_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ier_q[uifc_pkg::IE_SLEEP] |=> $stable(o_divisor))
    else $error("divisor changed in sleep");
  ier_lock_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !efr_q[uifc_pkg::EF_WREN] |=> (ier_q[7:4] == $past(ier_q[7:4])))
    else $error("locked enable bits changed");
  tcr_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !(efr_q[uifc_pkg::EF_WREN] && mcr_q[uifc_pkg::MC_ACCESS]) |=> $stable(tcr_q))
    else $error("threshold written without access");
  spec_set_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_rx_valid && efr_q[uifc_pkg::EF_SPECIAL] && i_rx_char == xoff2_q) |=> spec_q)
    else $error("special char not flagged");
  no_int_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !o_intr |-> interrupt_source_id[0])
    else $error("id bit 0 wrong when idle");
  fifo_mirror_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    interrupt_source_id[7:6] == {2{o_fifo_mode}})
    else $error("id mirror bits wrong");
  tx_rearm_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (!tx_pend_q && $past(i_tx_below) && i_tx_below) |=> !tx_pend_q)
    else $error("tx interrupt raised without fresh edge");
endmodule : uifc_top

// >>> verification/uifc_host_model.sv
`timescale 1ns/10ps
// ==========================================
// host processor on the 8-bit register bus
module uifc_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [2:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_addr = 3'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // ==========================================
  // idle data shows the inverse, so a stale byte never passes for a write
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = v;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~v;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    v = i_rdata;
    o_rd = 1'b0;
  endtask : rd
  task automatic bank(input logic [7:0] key);
    wr(uifc_pkg::ADDR_LCR, key);
  endtask : bank
endmodule : uifc_host_model

// >>> verification/tb.sv
`timescale 1ns/10ps
`define CHK(g, e, m) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e); \
    end \
  end
module tb;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rx_char = 8'h00;
  logic [6:0] rx_level = 7'h00;
  logic rx_valid = 1'b0;
  logic tx_below = 1'b0;
  logic line_err = 1'b0;
  logic rx_timeout = 1'b0;
  logic rx_ready = 1'b0;
  logic modem_chg = 1'b0;
  logic xoff_rcvd = 1'b0;
  logic cts_pin = 1'b0;
  logic rts_pin;
  logic tx_halt;
  logic intr;
  logic sleep;
  logic fifo_mode;
  logic [15:0] divisor;
  logic [3:0] sw_mode;
  logic [7:0] d;
  int bad_count = 0;
  int n_checks = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  uifc_host_model i_host (.i_clk(i_sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));
  uifc_top i_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wr(wr),
    .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .i_rx_valid(rx_valid), .i_rx_char(rx_char),
    .i_rx_level(rx_level), .i_tx_below(tx_below), .i_line_err(line_err),
    .i_rx_timeout(rx_timeout), .i_rx_ready(rx_ready), .i_modem_chg(modem_chg),
    .i_xoff_rcvd(xoff_rcvd), .i_cts_pin(cts_pin), .o_rts_pin(rts_pin), .o_tx_halt(tx_halt),
    .o_intr(intr), .o_sleep(sleep), .o_divisor(divisor), .o_sw_flow_mode(sw_mode),
    .o_fifo_mode(fifo_mode));
  // ==========================================
  // shared helpers
  task automatic enhanced_feature_ctrl(input logic [7:0] v);
    i_host.bank(uifc_pkg::LCR_ENH_KEY);
    i_host.wr(uifc_pkg::ADDR_IIR_FCR, v);
    i_host.bank(8'h00);
  endtask : enhanced_feature_ctrl
  task automatic interrupt_source_id(input logic [4:0] code, input logic pend, input logic fifo);
    i_host.rd(uifc_pkg::ADDR_IIR_FCR, d);
    `CHK(d, {fifo, fifo, code, ~pend}, "id")
  endtask : interrupt_source_id
  task automatic pulse(input logic [7:0] c, input logic x);
    @(negedge i_sys_clk);
    rx_char = c;
    rx_valid = ~x;
    xoff_rcvd = x;
    @(negedge i_sys_clk);
    rx_valid = 1'b0;
    xoff_rcvd = 1'b0;
    #1;
  endtask : pulse
  // rts is registered, so judged one cycle after the level moves
  task automatic lvl(input logic [6:0] v, input logic e);
    @(negedge i_sys_clk);
    rx_level = v;
    @(negedge i_sys_clk);
    `CHK(rts_pin, e, "rts")
  endtask : lvl
  task automatic pin(input logic v);
    @(negedge i_sys_clk);
    cts_pin = v;
    #1;
  endtask : pin
  // ==========================================
  // scenarios
  task t_reset();
    i_host.rd(uifc_pkg::ADDR_IER, d);
    `CHK(d, 8'h00, "enable reset")
    `CHK(divisor, 16'h0000, "divisor reset")
    `CHK(sleep, 1'b0, "sleep reset")
    interrupt_source_id(5'h00, 1'b0, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task t_lock();
    i_host.wr(uifc_pkg::ADDR_IER, 8'hF0);
    i_host.rd(uifc_pkg::ADDR_IER, d);
    `CHK(d, 8'h00, "locked enable")
    `CHK(sleep, 1'b0, "sleep locked")
    for (int m = 0; m < 16; m++)
    begin
      enhanced_feature_ctrl({4'h1, m[3:0]});
      `CHK(sw_mode, m[3:0], "flow mode")
    end
    $display("test lock done");
  endtask : t_lock
  task t_div();
    i_host.bank(8'h80);
    i_host.wr(uifc_pkg::ADDR_RX_TX, 8'h12);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h34);
    i_host.bank(8'h00);
    `CHK(divisor, 16'h3412, "divisor")
    i_host.wr(uifc_pkg::ADDR_IER, 8'h10); // divisor loaded first
    `CHK(sleep, 1'b1, "sleep on")
    i_host.bank(8'h80);
    i_host.wr(uifc_pkg::ADDR_RX_TX, 8'h56);
    i_host.bank(8'h00);
    `CHK(divisor, 16'h3412, "divisor in sleep")
    i_host.wr(uifc_pkg::ADDR_IER, 8'h00);
    `CHK(sleep, 1'b0, "sleep off")
    $display("test divisor done");
  endtask : t_div
  task t_prio();
    i_host.wr(uifc_pkg::ADDR_IIR_FCR, 8'h01);
    `CHK(fifo_mode, 1'b1, "fifo mode")
    @(negedge i_sys_clk);
    line_err = 1'b1;
    rx_timeout = 1'b1;
    rx_ready = 1'b1;
    modem_chg = 1'b1;
    #1;
    `CHK(intr, 1'b0, "all masked")
    i_host.wr(uifc_pkg::ADDR_IER, 8'h04);
    interrupt_source_id(uifc_pkg::ID_LINE, 1'b1, 1'b1);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h08);
    interrupt_source_id(uifc_pkg::ID_MODEM, 1'b1, 1'b1);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h0F);
    @(negedge i_sys_clk);
    tx_below = 1'b1;
    #1;
    `CHK(intr, 1'b1, "intr out")
    interrupt_source_id(uifc_pkg::ID_LINE, 1'b1, 1'b1);
    line_err = 1'b0;
    interrupt_source_id(uifc_pkg::ID_TIMEOUT, 1'b1, 1'b1);
    rx_timeout = 1'b0;
    interrupt_source_id(uifc_pkg::ID_RX, 1'b1, 1'b1);
    rx_ready = 1'b0;
    interrupt_source_id(uifc_pkg::ID_TX, 1'b1, 1'b1);
    interrupt_source_id(uifc_pkg::ID_MODEM, 1'b1, 1'b1);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h0D);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h0F);
    modem_chg = 1'b0;
    #1;
    `CHK(intr, 1'b0, "tx re-enable")
    interrupt_source_id(5'h00, 1'b0, 1'b1);
    tx_below = 1'b0;
    $display("test priority done");
  endtask : t_prio
  task t_flow();
    enhanced_feature_ctrl(8'h30);
    i_host.bank(uifc_pkg::LCR_ENH_KEY);
    i_host.wr(uifc_pkg::ADDR_TLR_XOFF2, 8'hA5);
    i_host.bank(8'h00);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h20);
    pulse(8'h5A, 1'b0);
    `CHK(intr, 1'b0, "no match")
    pulse(8'hA5, 1'b0);
    interrupt_source_id(uifc_pkg::ID_XOFF, 1'b1, 1'b1);
    pulse(8'h00, 1'b1);
    interrupt_source_id(uifc_pkg::ID_XOFF, 1'b1, 1'b1);
    interrupt_source_id(5'h00, 1'b0, 1'b1);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h00);
    pin(1'b1);
    `CHK(intr, 1'b0, "flow masked")
    pin(1'b0);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h80);
    pin(1'b1);
    interrupt_source_id(uifc_pkg::ID_FLOW, 1'b1, 1'b1);
    pin(1'b0);
    interrupt_source_id(5'h00, 1'b0, 1'b1);
    $display("test flow flags done");
  endtask : t_flow
  task t_auto();
    enhanced_feature_ctrl(8'h10);
    i_host.wr(uifc_pkg::ADDR_IER, 8'h00);
    i_host.wr(uifc_pkg::ADDR_MCR, 8'h40);
    i_host.wr(uifc_pkg::ADDR_TCR, 8'h24); // halt above resume
    i_host.wr(uifc_pkg::ADDR_MCR, 8'h00);
    enhanced_feature_ctrl(8'hD0); // thresholds before flow enable
    lvl(7'h0F, 1'b0);
    lvl(7'h10, 1'b1);
    lvl(7'h09, 1'b1);
    lvl(7'h08, 1'b0);
    i_host.wr(uifc_pkg::ADDR_TCR, 8'h12);
    lvl(7'h0C, 1'b0);
    i_host.wr(uifc_pkg::ADDR_MCR, 8'h40);
    i_host.wr(uifc_pkg::ADDR_TCR, 8'h12);
    lvl(7'h0C, 1'b1);
    lvl(7'h04, 1'b0);
    pin(1'b1);
    `CHK(tx_halt, 1'b1, "cts halt")
    pin(1'b0);
    `CHK(tx_halt, 1'b0, "cts resume")
    $display("test auto flow done");
  endtask : t_auto
  // ==========================================
  task results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    t_reset();
    t_lock();
    t_div();
    t_prio();
    t_flow();
    t_auto();
    results();
  end
  // whole run is under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end
endmodule : tb
